// >>> hw/uhcs_event_bit.sv
// One sticky event bit with soft reset clear and write-one clear
module uhcs_event_bit (
  // Clock and reset
  input  wire logic CLK_SYS_I,
  input  wire logic RESETN_I,
  // Control
  input  wire logic clear_i,
  input  wire logic set_i,
  input  wire logic wr_clr_i,
  // Status
  output logic      flag_o
);

  logic flag_q;
  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (wr_clr_i || clear_i) begin
      flag_d = 1'b0;
    end
    // A new event beats a clear in the same cycle
    if (set_i) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule : uhcs_event_bit

// >>> hw/uhcs_list_filled.sv
// One list-filled flag with its list processing sequencer
module uhcs_list_filled (
  // Clock and reset
  input  wire logic CLK_SYS_I,
  input  wire logic RESETN_I,
  // Control
  input  wire logic clear_i,
  input  wire logic sw_set_i,
  input  wire logic at_head_i,
  input  wire logic td_found_i,
  input  wire logic list_done_i,
  // Status
  output logic      filled_o,
  output logic      active_o
);

  logic                      filled_q;
  logic                      filled_d;
  uhcs_pkg::uhcs_list_state_t state_q;
  uhcs_pkg::uhcs_list_state_t state_d;

  always_comb begin
    filled_d = filled_q;
    state_d  = state_q;
    unique case (state_q)
      uhcs_pkg::LIST_IDLE: begin
        if (at_head_i && filled_q) begin
          // Flag consumed at the head; a descriptor restores it
          state_d  = uhcs_pkg::LIST_RUN;
          filled_d = 1'b0;
        end
      end
      uhcs_pkg::LIST_RUN: begin
        if (td_found_i) begin
          filled_d = 1'b1;
        end
        if (list_done_i) begin
          state_d = uhcs_pkg::LIST_IDLE;
        end
      end
    endcase
    // Software set wins over the consume in the same cycle
    if (sw_set_i) begin
      filled_d = 1'b1;
    end
    if (clear_i) begin
      filled_d = 1'b0;
      state_d  = uhcs_pkg::LIST_IDLE;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      filled_q <= 1'b0;
      state_q  <= uhcs_pkg::LIST_IDLE;
    end else begin
      filled_q <= filled_d;
      state_q  <= state_d;
    end
  end

  assign filled_o = filled_q;
  assign active_o = (state_q == uhcs_pkg::LIST_RUN);

endmodule : uhcs_list_filled

// >>> hw/uhcs_pkg.sv
// Package: register map, field layout, reset values and timing for the command status block
package uhcs_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] OFF_CMD_STATUS  = 12'h008;
  localparam logic [11:0] OFF_EVT_STATUS  = 12'h00C;
  localparam logic [11:0] OFF_EVT_ENABLE  = 12'h010;
  localparam logic [11:0] OFF_EVT_CLEAR   = 12'h014;
  localparam logic [11:0] OFF_SEQ_CTRL    = 12'h018;

  // ****************************************************************
  // Command status field positions
  // ****************************************************************
  localparam int unsigned BIT_SOFT_RESET   = 0;
  localparam int unsigned BIT_CTRL_FILLED  = 1;
  localparam int unsigned BIT_BULK_FILLED  = 2;
  localparam int unsigned BIT_OWN_REQ      = 3;
  localparam int unsigned BIT_OVR_CNT_LO   = 16;
  localparam int unsigned BIT_OVR_CNT_HI   = 17;

  // ****************************************************************
  // Event status field positions
  // ****************************************************************
  localparam int unsigned EVT_SCHED_OVR    = 0;
  localparam int unsigned EVT_OWNER_SWITCH = 30;
  localparam int unsigned EVT_WIDTH        = 2;

  // ****************************************************************
  // Sequencer control field positions
  // ****************************************************************
  localparam int unsigned BIT_SEQ_SUSPEND  = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [1:0] RST_OVR_CNT  = 2'h0;
  localparam logic [3:0] RST_CMD_BITS = 4'h0;
  localparam logic [1:0] RST_EVT      = 2'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS       = 10;
  localparam int unsigned SOFT_RESET_TIME_NS  = 200;
  localparam int unsigned SOFT_RESET_CYCLES   =
    (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SOFT_RESET_CNT_W    = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       own_req;
    logic       bulk_filled;
    logic       ctrl_filled;
    logic       soft_reset;
  } uhcs_cmd_t;

  typedef struct packed {
    logic       owner_switch;
    logic       sched_ovr;
  } uhcs_evt_t;

  typedef enum logic [1:0] {
    LIST_IDLE,
    LIST_RUN
  } uhcs_list_state_t;

endpackage : uhcs_pkg

// >>> hw/uhcs_top.sv
// Command status register block of a USB host controller with APB access
//
// Summary of operation
// - Writes only set bits; zeros keep value
// - Every command status bit reads back normally
// - Periodic overrun counts and sets overrun event
// - Two-bit counter at 17:16, wraps
// - Counter increments even with event already set
// - Ownership request sets owner switch event
// - Request clears after changeover completes
// - Bulk filled zero blocks bulk processing
// - Bulk head clears flag; descriptor sets again
// - No descriptor leaves flag zero; bulk halts
// - Control filled gates start, clear, reset
// - No control descriptor leaves zero; halts
// - Soft reset suspends, resets registers, blocks bus
// - Controller clears soft reset bit when done
// - Soft reset leaves root hub untouched
// - Overrun event after frame number update
module uhcs_top (
  // Clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESETN_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Schedule engine events
  input  wire logic        PERIODIC_OVERRUN_I,
  input  wire logic        FRAME_NUM_UPDATED_I,
  input  wire logic        OWN_CHANGE_DONE_I,
  input  wire logic        CTRL_HEAD_I,
  input  wire logic        CTRL_TD_FOUND_I,
  input  wire logic        CTRL_DONE_I,
  input  wire logic        BULK_HEAD_I,
  input  wire logic        BULK_TD_FOUND_I,
  input  wire logic        BULK_DONE_I,
  // Controller status
  output logic             CTRL_ACTIVE_O,
  output logic             BULK_ACTIVE_O,
  output logic             SUSPEND_O,
  output logic             OPREG_RESET_O,
  output logic             HOST_BUS_BLOCK_O,
  output logic             IRQ_O
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic       wr_en;
  logic       rd_en;
  logic       hit_cmd;
  logic       hit_evt;
  logic       hit_ena;
  logic       hit_clr;
  logic       hit_seq;
  logic       mapped;

  assign wr_en   = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
  assign rd_en   = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign hit_cmd = (PADDR_I == uhcs_pkg::OFF_CMD_STATUS);
  assign hit_evt = (PADDR_I == uhcs_pkg::OFF_EVT_STATUS);
  assign hit_ena = (PADDR_I == uhcs_pkg::OFF_EVT_ENABLE);
  assign hit_clr = (PADDR_I == uhcs_pkg::OFF_EVT_CLEAR);
  assign hit_seq = (PADDR_I == uhcs_pkg::OFF_SEQ_CTRL);
  assign mapped  = hit_cmd || hit_evt || hit_ena || hit_clr || hit_seq;

  // ****************************************************************
  // Command and sequencer write decode
  // ****************************************************************
  uhcs_pkg::uhcs_cmd_t cmd_wr;
  logic                resume_req;

  // Write-one-to-set: only the ones of a command write act, zeros are no-ops
  assign cmd_wr = (wr_en && hit_cmd) ?
    uhcs_pkg::uhcs_cmd_t'(PWDATA_I[uhcs_pkg::BIT_OWN_REQ:uhcs_pkg::BIT_SOFT_RESET]) :
    uhcs_pkg::uhcs_cmd_t'(uhcs_pkg::RST_CMD_BITS);
  assign resume_req = wr_en && hit_seq && PWDATA_I[uhcs_pkg::BIT_SEQ_SUSPEND];

  // ****************************************************************
  // Soft reset sequencer
  // ****************************************************************
  logic                                  srst_q;
  logic                                  srst_d;
  logic [uhcs_pkg::SOFT_RESET_CNT_W-1:0] srst_cnt_q;
  logic [uhcs_pkg::SOFT_RESET_CNT_W-1:0] srst_cnt_d;
  logic                                  susp_q;
  logic                                  susp_d;
  logic                                  srst_start;
  logic                                  srst_clear;

  // Write one to the reset bit starts the sequence; a zero is ignored
  assign srst_start = cmd_wr.soft_reset && !srst_q;
  // Operational state is held in reset while the sequence runs
  assign srst_clear = srst_q;

  always_comb begin
    srst_d     = srst_q;
    srst_cnt_d = srst_cnt_q;
    susp_d     = susp_q;
    if (srst_start) begin
      srst_d     = 1'b1;
      srst_cnt_d = uhcs_pkg::SOFT_RESET_CNT_W'(uhcs_pkg::SOFT_RESET_CYCLES);
      susp_d     = 1'b1;
    end else if (srst_q) begin
      if (srst_cnt_q == '0) begin
        srst_d = 1'b0;
      end else begin
        srst_cnt_d = srst_cnt_q - 1'b1;
      end
    end else if (resume_req) begin
      // Leaving suspend is the wider controller's job; a hook is given here
      susp_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      srst_q     <= 1'b0;
      srst_cnt_q <= '0;
      susp_q     <= 1'b0;
    end else begin
      srst_q     <= srst_d;
      srst_cnt_q <= srst_cnt_d;
      susp_q     <= susp_d;
    end
  end

  // ****************************************************************
  // Ownership change request
  // ****************************************************************
  logic own_q;
  logic own_d;
  logic own_set;

  assign own_set = cmd_wr.own_req;

  always_comb begin
    own_d = own_q;
    if (OWN_CHANGE_DONE_I) begin
      own_d = 1'b0;
    end
    if (own_set) begin
      own_d = 1'b1;
    end
    // A running soft reset holds the request clear, even against a write
    if (srst_clear) begin
      own_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      own_q <= 1'b0;
    end else begin
      own_q <= own_d;
    end
  end

  // ****************************************************************
  // Scheduling overrun counter
  // ****************************************************************
  logic [1:0] ovr_cnt_q;
  logic [1:0] ovr_cnt_d;
  logic       ovr_pend_q;
  logic       ovr_pend_d;
  logic       ovr_event;

  // Event waits for the frame number update before it is posted
  always_comb begin
    ovr_pend_d = ovr_pend_q;
    ovr_event  = 1'b0;
    if (PERIODIC_OVERRUN_I) begin
      ovr_pend_d = 1'b1;
    end
    // An overrun flagged in the update cycle itself is posted at once
    if ((ovr_pend_q || PERIODIC_OVERRUN_I) && FRAME_NUM_UPDATED_I) begin
      ovr_event  = 1'b1;
      ovr_pend_d = 1'b0;
    end
    if (srst_clear) begin
      ovr_pend_d = 1'b0;
      ovr_event  = 1'b0;
    end
  end

  always_comb begin
    ovr_cnt_d = ovr_cnt_q;
    if (srst_clear) begin
      ovr_cnt_d = uhcs_pkg::RST_OVR_CNT;
    end else if (PERIODIC_OVERRUN_I) begin
      // Natural two-bit wrap, independent of the event flag
      ovr_cnt_d = ovr_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      ovr_cnt_q  <= uhcs_pkg::RST_OVR_CNT;
      ovr_pend_q <= 1'b0;
    end else begin
      ovr_cnt_q  <= ovr_cnt_d;
      ovr_pend_q <= ovr_pend_d;
    end
  end

  // ****************************************************************
  // List filled flags
  // ****************************************************************
  logic ctrl_filled;
  logic bulk_filled;
  logic ctrl_active;
  logic bulk_active;

  uhcs_list_filled u_ctrl_list (
    .CLK_SYS_I   (CLK_SYS_I),
    .RESETN_I    (RESETN_I),
    .clear_i     (srst_clear),
    .sw_set_i    (cmd_wr.ctrl_filled),
    .at_head_i   (CTRL_HEAD_I),
    .td_found_i  (CTRL_TD_FOUND_I),
    .list_done_i (CTRL_DONE_I),
    .filled_o    (ctrl_filled),
    .active_o    (ctrl_active)
  );

  uhcs_list_filled u_bulk_list (
    .CLK_SYS_I   (CLK_SYS_I),
    .RESETN_I    (RESETN_I),
    .clear_i     (srst_clear),
    .sw_set_i    (cmd_wr.bulk_filled),
    .at_head_i   (BULK_HEAD_I),
    .td_found_i  (BULK_TD_FOUND_I),
    .list_done_i (BULK_DONE_I),
    .filled_o    (bulk_filled),
    .active_o    (bulk_active)
  );

  // ****************************************************************
  // Event status, enable and interrupt
  // ****************************************************************
  uhcs_pkg::uhcs_evt_t evt_flags;
  uhcs_pkg::uhcs_evt_t evt_set;
  logic [1:0]          evt_wclr;
  logic [1:0]          ena_q;
  logic [1:0]          ena_d;
  logic                irq_any;

  assign evt_set.sched_ovr    = ovr_event;
  // No new ownership event while a soft reset holds the flags clear
  assign evt_set.owner_switch = own_set && !srst_q;
  assign evt_wclr = (wr_en && hit_clr) ?
    {PWDATA_I[uhcs_pkg::EVT_OWNER_SWITCH], PWDATA_I[uhcs_pkg::EVT_SCHED_OVR]} : 2'h0;

  for (genvar i = 0; i < uhcs_pkg::EVT_WIDTH; i++) begin : g_evt
    uhcs_event_bit u_evt (
      .CLK_SYS_I (CLK_SYS_I),
      .RESETN_I  (RESETN_I),
      .clear_i   (srst_clear),
      .set_i     (evt_set[i]),
      .wr_clr_i  (evt_wclr[i]),
      .flag_o    (evt_flags[i])
    );
  end

  always_comb begin
    ena_d = ena_q;
    if (srst_clear) begin
      ena_d = uhcs_pkg::RST_EVT;
    end else if (wr_en && hit_ena) begin
      ena_d = {PWDATA_I[uhcs_pkg::EVT_OWNER_SWITCH], PWDATA_I[uhcs_pkg::EVT_SCHED_OVR]};
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      ena_q <= uhcs_pkg::RST_EVT;
    end else begin
      ena_q <= ena_d;
    end
  end

  // Level request: any enabled sticky flag, registered at the pin
  assign irq_any = |(evt_flags & ena_q);

  // ****************************************************************
  // Read mux and registered outputs
  // ****************************************************************
  logic [31:0] rdata;
  logic        slverr;

  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_cmd) begin
      rdata[uhcs_pkg::BIT_SOFT_RESET]                        = srst_q;
      rdata[uhcs_pkg::BIT_CTRL_FILLED]                       = ctrl_filled;
      rdata[uhcs_pkg::BIT_BULK_FILLED]                       = bulk_filled;
      rdata[uhcs_pkg::BIT_OWN_REQ]                           = own_q;
      rdata[uhcs_pkg::BIT_OVR_CNT_HI:uhcs_pkg::BIT_OVR_CNT_LO] = ovr_cnt_q;
    end else if (hit_evt) begin
      rdata[uhcs_pkg::EVT_SCHED_OVR]    = evt_flags.sched_ovr;
      rdata[uhcs_pkg::EVT_OWNER_SWITCH] = evt_flags.owner_switch;
    end else if (hit_ena) begin
      rdata[uhcs_pkg::EVT_SCHED_OVR]    = ena_q[0];
      rdata[uhcs_pkg::EVT_OWNER_SWITCH] = ena_q[1];
    end else if (hit_seq) begin
      rdata[uhcs_pkg::BIT_SEQ_SUSPEND] = susp_q;
    end
    slverr = !mapped;
  end

  // Access phase answers one cycle after setup: PREADY high in every access cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      PRDATA_O         <= 32'h0000_0000;
      PREADY_O         <= 1'b0;
      PSLVERR_O        <= 1'b0;
      IRQ_O            <= 1'b0;
      CTRL_ACTIVE_O    <= 1'b0;
      BULK_ACTIVE_O    <= 1'b0;
      SUSPEND_O        <= 1'b0;
      OPREG_RESET_O    <= 1'b0;
      HOST_BUS_BLOCK_O <= 1'b0;
    end else begin
      PREADY_O  <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && slverr;
      if (rd_en) begin
        PRDATA_O <= rdata;
      end
      IRQ_O            <= irq_any;
      CTRL_ACTIVE_O    <= ctrl_active;
      BULK_ACTIVE_O    <= bulk_active;
      SUSPEND_O        <= susp_d;
      OPREG_RESET_O    <= srst_d;
      HOST_BUS_BLOCK_O <= srst_d;
    end
  end

endmodule : uhcs_top

// >>> sim/tb_uhcs_top.sv
// Testbench: APB-driven checks of the command status block
module tb_uhcs_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CMD = uhcs_pkg::OFF_CMD_STATUS;
  localparam logic [11:0] A_EST = uhcs_pkg::OFF_EVT_STATUS;
  localparam logic [11:0] A_EN  = uhcs_pkg::OFF_EVT_ENABLE;
  localparam logic [11:0] A_CLR = uhcs_pkg::OFF_EVT_CLEAR;
  localparam logic [11:0] A_SEQ = uhcs_pkg::OFF_SEQ_CTRL;
  logic        clk;
  logic        rst_n_q;
  logic        psel_q;
  logic        pen_q;
  logic        pwr_q;
  logic [11:0] padr_q;
  logic [31:0] pwd_q;
  logic [8:0]  ev_q;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ctrl_act;
  logic        bulk_act;
  logic        susp;
  logic        opreg_rst;
  logic        bus_blk;
  logic        irq;
  logic [31:0] rdata;
  logic        slverr;
  logic [31:0] m;
  logic [31:0] base;
  int          err_count;
  int          n_tests;
  int          n;
  int          h;

  uhcs_top u_uhcs_top (
    .CLK_SYS_I(clk), .RESETN_I(rst_n_q), .PSEL_I(psel_q), .PENABLE_I(pen_q),
    .PWRITE_I(pwr_q), .PADDR_I(padr_q), .PWDATA_I(pwd_q), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PERIODIC_OVERRUN_I(ev_q[0]),
    .FRAME_NUM_UPDATED_I(ev_q[1]), .OWN_CHANGE_DONE_I(ev_q[2]), .CTRL_HEAD_I(ev_q[3]),
    .CTRL_TD_FOUND_I(ev_q[4]), .CTRL_DONE_I(ev_q[5]), .BULK_HEAD_I(ev_q[6]),
    .BULK_TD_FOUND_I(ev_q[7]), .BULK_DONE_I(ev_q[8]), .CTRL_ACTIVE_O(ctrl_act),
    .BULK_ACTIVE_O(bulk_act), .SUSPEND_O(susp), .OPREG_RESET_O(opreg_rst),
    .HOST_BUS_BLOCK_O(bus_blk), .IRQ_O(irq));

  always #5 clk = ~clk;

  // *****
  // Tasks
  // *****
  task automatic wrap_up();
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Entered just after an edge; leaves one idle edge so strobes never double up
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel_q <= 1'b1;
    pen_q  <= 1'b0;
    pwr_q  <= w;
    padr_q <= a;
    pwd_q  <= d;
    @(posedge clk);
    pen_q <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    chk("ready wait", k < 16, 1);
    rdata  = prdata;
    slverr = pslverr;
    psel_q <= 1'b0;
    pen_q  <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rdata, e);
  endtask : rd

  // Outputs lag the event by two edges, so wait them out here
  task automatic pulse(input int i);
    ev_q[i] <= 1'b1;
    @(posedge clk);
    ev_q[i] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  function automatic logic [31:0] actv(input int l);
    return {31'h0, (l == 1) ? bulk_act : ctrl_act};
  endfunction : actv

  // *****
  // Tests
  // *****
  initial begin
    clk = 1'b0;
    rst_n_q = 1'b0;
    psel_q = 1'b0;
    pen_q = 1'b0;
    pwr_q = 1'b0;
    padr_q = 12'h000;
    pwd_q = 32'h0000_0000;
    ev_q = 9'h000;
    err_count = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    rst_n_q <= 1'b1;
    @(posedge clk);
    rd(A_CMD, 32'h0000_0000, "cmd reset");
    rd(A_EST, 32'h0000_0000, "evt reset");
    apb(1'b1, A_CMD, 32'hFFFF_FFF6);
    rd(A_CMD, 32'h0000_0006, "cmd set");
    apb(1'b1, A_CMD, 32'h0000_0000);
    rd(A_CMD, 32'h0000_0006, "cmd keep");
    apb(1'b1, A_EN, 32'h4000_0000);
    apb(1'b1, A_CMD, 32'h0000_0008);
    rd(A_CMD, 32'h0000_000E, "own req");
    rd(A_EST, 32'h4000_0000, "own evt");
    chk("irq own", {31'h0, irq}, 32'h1);
    pulse(2);
    rd(A_CMD, 32'h0000_0006, "own done");
    apb(1'b1, A_CLR, 32'h4000_0000);
    rd(A_CLR, 32'h0000_0000, "clr reads zero");
    rd(A_EST, 32'h0000_0000, "evt cleared");
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b1, A_EN, 32'h0000_0000);
    apb(1'b1, A_CMD, 32'h0000_0008);
    rd(A_EST, 32'h4000_0000, "masked evt");
    chk("irq masked", {31'h0, irq}, 32'h0);
    pulse(2);
    apb(1'b1, A_CLR, 32'h4000_0000);
    // Control list first, then bulk; bulk flag still set meanwhile
    for (int l = 0; l < 2; l++) begin
      h = 3 + 3 * l;
      m = 32'h2 << l;
      base = (l == 1) ? 32'h0 : 32'h4;
      pulse(h);
      chk("list start", actv(l), 32'h1);
      rd(A_CMD, base, "head clears");
      pulse(h + 1);
      rd(A_CMD, base | m, "td sets");
      pulse(h + 2);
      pulse(h);
      chk("list rerun", actv(l), 32'h1);
      pulse(h + 2);
      rd(A_CMD, base, "no td");
      chk("list halt", actv(l), 32'h0);
      pulse(h);
      chk("no start", actv(l), 32'h0);
    end
    apb(1'b1, A_EN, 32'h0000_0001);
    pulse(0);
    rd(A_EST, 32'h0000_0000, "ovr before frame");
    pulse(1);
    rd(A_EST, 32'h0000_0001, "ovr evt");
    chk("irq ovr", {31'h0, irq}, 32'h1);
    rd(A_CMD, 32'h0001_0000, "ovr cnt");
    for (int i = 2; i < 6; i++) begin
      pulse(0);
      rd(A_CMD, (i % 4) << 16, "ovr cnt wrap");
    end
    apb(1'b1, A_CMD, 32'h0000_0006);
    apb(1'b1, A_CMD, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("srst run", {29'h0, opreg_rst, bus_blk, susp}, 32'h7);
    apb(1'b1, A_CMD, 32'h0000_000E);
    n = 0;
    do begin
      apb(1'b0, A_CMD, 32'h0000_0000);
      n++;
    end while (rdata[0] !== 1'b0 && n < 40);
    chk("srst self clear", {31'h0, rdata[0]}, 32'h0);
    rd(A_CMD, 32'h0000_0000, "srst regs");
    rd(A_EST, 32'h0000_0000, "srst events");
    rd(A_EN, 32'h0000_0000, "srst enable");
    chk("srst end", {30'h0, opreg_rst, bus_blk}, 32'h0);
    rd(A_SEQ, 32'h0000_0001, "suspended");
    apb(1'b1, A_SEQ, 32'h0000_0001);
    rd(A_SEQ, 32'h0000_0000, "resumed");
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    chk("slverr wr", {31'h0, slverr}, 32'h1);
    rd(12'h0FC, 32'h0000_0000, "unmapped rd");
    chk("slverr rd", {31'h0, slverr}, 32'h1);
    rd(A_CMD, 32'h0000_0000, "unmapped no effect");
    wrap_up();
  end

  // Run needs about 2.5 us; a hang is cut well past that
  initial begin
    #100us;
    err_count++;
    wrap_up();
  end
endmodule : tb_uhcs_top

bind uhcs_top uhcs_asserts u_uhcs_asserts (
  .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .CTRL_HEAD_I(CTRL_HEAD_I), .BULK_HEAD_I(BULK_HEAD_I),
  .CTRL_ACTIVE_O(CTRL_ACTIVE_O), .BULK_ACTIVE_O(BULK_ACTIVE_O), .SUSPEND_O(SUSPEND_O),
  .OPREG_RESET_O(OPREG_RESET_O), .HOST_BUS_BLOCK_O(HOST_BUS_BLOCK_O), .IRQ_O(IRQ_O));

// >>> sim/uhcs_asserts.sv
// Checker: port-level assertions for the command status block
module uhcs_asserts (
  // Clock and reset
  input wire logic        CLK_SYS_I,
  input wire logic        RESETN_I,
  // APB
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // Lists and status
  input wire logic        CTRL_HEAD_I,
  input wire logic        BULK_HEAD_I,
  input wire logic        CTRL_ACTIVE_O,
  input wire logic        BULK_ACTIVE_O,
  input wire logic        SUSPEND_O,
  input wire logic        OPREG_RESET_O,
  input wire logic        HOST_BUS_BLOCK_O,
  input wire logic        IRQ_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);

  logic mapped;
  assign mapped = PADDR_I inside {uhcs_pkg::OFF_CMD_STATUS, uhcs_pkg::OFF_EVT_STATUS,
    uhcs_pkg::OFF_EVT_ENABLE, uhcs_pkg::OFF_EVT_CLEAR, uhcs_pkg::OFF_SEQ_CTRL};

  // Length of the current soft reset, in cycles; a repetition cannot count this far
  logic [7:0] srst_len;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I || !OPREG_RESET_O) begin
      srst_len <= 8'h00;
    end else begin
      srst_len <= srst_len + 8'h01;
    end
  end

  // *****
  // Sequences
  // *****
  sequence s_setup;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence s_acc;
    PSEL_I && PENABLE_I && PREADY_O;
  endsequence
  sequence s_srst_run;
    OPREG_RESET_O [*8];
  endsequence

  // *****
  // Assertions
  // *****
  AST_READY: assert property (s_setup |=> PREADY_O)
    else $error("No ready after setup");
  AST_PULSE: assert property (s_acc |=> !PREADY_O)
    else $error("Ready held past access");
  AST_SLVERR: assert property (s_acc |-> PSLVERR_O == !mapped)
    else $error("Error response wrong for address");
  AST_RSVD: assert property (s_acc ##0 (!PWRITE_I
    && PADDR_I == uhcs_pkg::OFF_CMD_STATUS)
    |-> PRDATA_O[31:18] == 14'h0 && PRDATA_O[15:4] == 12'h000)
    else $error("Reserved bits read nonzero");
  AST_SRST_LEN: assert property ($rose(OPREG_RESET_O) |-> s_srst_run
    ##1 OPREG_RESET_O [*8] ##1 OPREG_RESET_O [*5] ##1 !OPREG_RESET_O)
    else $error("Soft reset length wrong");
  AST_SRST_CNT: assert property ($fell(OPREG_RESET_O)
    |-> srst_len == uhcs_pkg::SOFT_RESET_CYCLES + 1)
    else $error("Soft reset cycle count wrong");
  AST_SUSP: assert property ($rose(OPREG_RESET_O) |-> ##[0:2] SUSPEND_O)
    else $error("Soft reset did not suspend");
  AST_BLOCK: assert property (HOST_BUS_BLOCK_O == OPREG_RESET_O)
    else $error("Bus block differs from soft reset");
  AST_BULK_START: assert property ($rose(BULK_ACTIVE_O)
    |-> $past(BULK_HEAD_I, 1) || $past(BULK_HEAD_I, 2) || $past(BULK_HEAD_I, 3))
    else $error("Bulk started without head");
  AST_CTRL_START: assert property ($rose(CTRL_ACTIVE_O)
    |-> $past(CTRL_HEAD_I, 1) || $past(CTRL_HEAD_I, 2) || $past(CTRL_HEAD_I, 3))
    else $error("Control started without head");
  AST_RST_OUT: assert property (disable iff (1'b0) !RESETN_I
    |=> !PREADY_O && !IRQ_O && !OPREG_RESET_O && !SUSPEND_O)
    else $error("Outputs not clear in reset");
endmodule : uhcs_asserts
